// ===== tccu_pkg.sv
// Constants shared by the timer capture/compare unit
`default_nettype none

package tccu_pkg;

  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Byte offsets of the register map
  localparam logic [7:0] CTL_ONE_OFS = 8'h00;
  localparam logic [7:0] CTL_TWO_OFS = 8'h01;
  localparam logic [7:0] STATUS_OFS = 8'h02;
  localparam logic [1:0][7:0] CAP_HI_OFS = {8'h07, 8'h03};
  localparam logic [1:0][7:0] CAP_LO_OFS = {8'h08, 8'h04};
  localparam logic [1:0][7:0] CMP_HI_OFS = {8'h09, 8'h05};
  localparam logic [1:0][7:0] CMP_LO_OFS = {8'h0a, 8'h06};
  localparam logic [7:0] CNT_HI_OFS = 8'h0b;
  localparam logic [7:0] CNT_LO_OFS = 8'h0c;
  localparam logic [7:0] ALT_HI_OFS = 8'h0d;
  localparam logic [7:0] ALT_LO_OFS = 8'h0e;

  // timer_control_one bit positions
  localparam int CAP_IRQ_EN_BIT = 7;
  localparam int CMP_IRQ_EN_BIT = 6;
  localparam int OVF_IRQ_EN_BIT = 5;
  localparam int FORCE_BIT [2] = '{3, 4};
  localparam int LEVEL_BIT [2] = '{0, 2};
  localparam int EDGE_ONE_BIT = 1;

  // timer_control_two bit positions
  localparam int OE_BIT [2] = '{7, 6};
  localparam int PULSE_BIT = 5;
  localparam int PWM_BIT = 4;
  localparam int CKSEL_MSB = 3;
  localparam int CKSEL_LSB = 2;
  localparam int EDGE_TWO_BIT = 1;
  localparam int EXT_EDGE_BIT = 0;

  // timer_status_reg bit positions
  localparam int CAP_FLAG_BIT [2] = '{7, 4};
  localparam int CMP_FLAG_BIT [2] = '{6, 3};
  localparam int OVF_FLAG_BIT = 5;

  // Reset, reload and rollover values
  localparam logic [15:0] CNT_RST = 16'hfffc;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CMP_RST = 16'h8000;

  // Counter clock selection codes and prescaler masks
  localparam logic [1:0] CKSEL_DIV4 = 2'h0;
  localparam logic [1:0] CKSEL_DIV2 = 2'h1;
  localparam logic [1:0] CKSEL_DIV8 = 2'h2;
  localparam logic [1:0] CKSEL_EXT = 2'h3;
  localparam logic [2:0] PRE_MASK_DIV2 = 3'h1;
  localparam logic [2:0] PRE_MASK_DIV4 = 3'h3;
  localparam logic [2:0] PRE_MASK_DIV8 = 3'h7;

endpackage

`default_nettype wire

// ===== tccu_tick.sv
// Counter advance pulse: prescaled CPU clock or external clock edge
`default_nettype none

module tccu_tick (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] clock_select,
  input wire logic ext_clk_pin,
  input wire logic ext_edge_select,
  output logic tick
);

  typedef struct packed {
    logic [2:0] pre;
    logic [2:0] ext_sync;
    logic tick;
  } tccu_tick_t;

  tccu_tick_t st_q;
  tccu_tick_t st_d;
  logic [2:0] mask;
  logic ext_edge;

  // Only stages one and two feed the edge detector, never stage zero
  assign ext_edge = ext_edge_select ? (st_q.ext_sync[1] & ~st_q.ext_sync[2])
                                    : (~st_q.ext_sync[1] & st_q.ext_sync[2]);

  // Prescaler mask per selection
  always_comb begin
    case (clock_select)
      tccu_pkg::CKSEL_DIV2: mask = tccu_pkg::PRE_MASK_DIV2;
      tccu_pkg::CKSEL_DIV4: mask = tccu_pkg::PRE_MASK_DIV4;
      tccu_pkg::CKSEL_DIV8: mask = tccu_pkg::PRE_MASK_DIV8;
      default: mask = tccu_pkg::PRE_MASK_DIV8;
    endcase
  end

  // Free-running prescaler; external clock needs four CPU clocks per edge
  always_comb begin
    st_d = st_q;
    st_d.pre = st_q.pre + 3'h1;
    st_d.ext_sync = {st_q.ext_sync[1:0], ext_clk_pin};
    if (clock_select == tccu_pkg::CKSEL_EXT) begin
      st_d.tick = ext_edge; // RULE_24
    end else begin
      st_d.tick = ((st_q.pre & mask) == mask); // RULE_24
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule

`default_nettype wire

// ===== tccu_core.sv
// Capture/compare stages of the 16-bit free-running timer
// What this block does
// [RULE_01] Each capture pin edge copies the counter into its capture value.
// [RULE_02] Capture values are read-only; writes leave them unchanged.
// [RULE_03] Each capture channel has its own rising/falling edge select bit.
// [RULE_04] Capture sets its flag; interrupt when enabled and CPU mask clear.
// [RULE_05] Capture flag clears after status read then low-byte access.
// [RULE_06] Reading capture high byte blocks captures until low byte read.
// [RULE_07] Newer captures overwrite older capture values.
// [RULE_08] In single-pulse or PWM mode only capture channel two works.
// [RULE_09] Capture pins always feed capture logic, even when driven as outputs.
// [RULE_10] Capture flag appears two to three clocks after the pin event.
// [RULE_11] Both compare values are checked against the counter each tick.
// [RULE_12] Match sets compare flag, drives level, may raise the interrupt.
// [RULE_13] Compare values are software read/write; reset loads 8000h.
// [RULE_14] Compare pin latches are low during reset.
// [RULE_15] Compare flag clears after status read then low-byte access.
// [RULE_16] High-byte write suspends compare until low-byte write.
// [RULE_17] Software should write high byte, read status, then low byte.
// [RULE_18] With output disabled, no level on match; flag still sets.
// [RULE_19] Flag and pin update during the counter state equal to compare.
// [RULE_20] Force bit copies level to pin with no flag and no interrupt.
// [RULE_21] Force bits do nothing in single-pulse or PWM mode.
// [RULE_22] Software updates compare value and level after each match.
// [RULE_23] Counter counts up; rollover to zero sets the overflow flag.
// [RULE_24] Counter advances at CPU clock /2, /4, /8 or external clock.
// [RULE_25] Counter resets to FFFCh; low or alternate low write reloads it.
// [RULE_26] Capture pins pass a two-stage synchroniser before edge detection.
// [RULE_27] A capture in the cycle of a status read keeps its flag set.
//
// Local design decisions: the strobed register port and the address map.
`default_nettype none

module tccu_core (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] capture_pin,
  input wire logic ext_clk_pin,
  input wire logic cpu_irq_mask,
  output logic [1:0] compare_pin,
  output logic [1:0] compare_output_enable,
  output logic timer_irq
);

  // Core state, apart from the prescaler and clock sync in tccu_tick, in one packed word, so reset and update stay together
  // Capture sync stages, flags and pin latches all live here, no stray registers
  typedef struct packed {
    logic [15:0] cnt;
    logic cnt_new;
    logic [7:0] cnt_buf;
    logic cnt_buf_valid;
    logic [1:0][15:0] cap;
    logic [1:0][15:0] cmp;
    logic [7:0] ctl_one;
    logic [7:0] ctl_two;
    logic [1:0] cap_flag;
    logic [1:0] cap_arm;
    logic [1:0] cap_inh;
    logic [1:0] cmp_flag;
    logic [1:0] cmp_arm;
    logic [1:0] cmp_inh;
    logic ovf_flag;
    logic ovf_arm;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] pin;
    logic [7:0] rdata;
  } tccu_core_t;

  tccu_core_t st_q;
  tccu_core_t st_d;
  // Combinational helpers derived from the registered state
  logic tick;
  logic pulse_mode;
  logic pwm_mode;
  logic special_mode;
  logic [1:0] edge_sel;
  logic [1:0] cap_event;
  logic [1:0] cmp_match;
  logic [7:0] status_view;

  // Register access decode, used for every address of the map
  // The strobe is folded in, so an address alone never decodes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs,
                               input logic strobe);
    hit = strobe && (a == ofs);
  endfunction

  // Counter advance pulse from the prescaler or external clock
  // The pulse is registered there, so the count moves one clock later
  tccu_tick u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .clock_select(st_q.ctl_two[tccu_pkg::CKSEL_MSB:tccu_pkg::CKSEL_LSB]),
    .ext_clk_pin(ext_clk_pin),
    .ext_edge_select(st_q.ctl_two[tccu_pkg::EXT_EDGE_BIT]),
    .tick(tick)
  );

  // Mode decode; PWM wins when both mode bits are set
  // Limitation: the waveform generators themselves are not built here
  assign pwm_mode = st_q.ctl_two[tccu_pkg::PWM_BIT];
  assign pulse_mode = st_q.ctl_two[tccu_pkg::PULSE_BIT] & ~pwm_mode;
  assign special_mode = pulse_mode | pwm_mode;

  // Each channel owns an edge select bit in a different control register
  // Both bits reset to zero, which selects the falling edge
  assign edge_sel[0] = st_q.ctl_one[tccu_pkg::EDGE_ONE_BIT]; // RULE_03
  assign edge_sel[1] = st_q.ctl_two[tccu_pkg::EDGE_TWO_BIT]; // RULE_03

  // Edge detect on synchronised samples; stage one is never looked at here
  // An edge seen here sets the flag one edge later, three clocks in all
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cap
      logic rise;
      logic fall;
      logic allowed;
      assign rise = st_q.sync2[g] & ~st_q.sync3[g]; // RULE_10
      assign fall = ~st_q.sync2[g] & st_q.sync3[g];
      // Channel one belongs to single-pulse and PWM generation
      assign allowed = (g == 1) || !special_mode; // RULE_08
      // Only the mode gate and the high-byte inhibit mask events; self-inflicted output toggles are captured
      assign cap_event[g] = (edge_sel[g] ? rise : fall) && allowed &&
                            !st_q.cap_inh[g]; // RULE_06 RULE_09
      // Compare only once per new counter state, while not suspended
      // A suspended channel skips the match but keeps the flag it has
      assign cmp_match[g] = st_q.cnt_new && !st_q.cmp_inh[g] &&
                            (st_q.cnt == st_q.cmp[g]); // RULE_11 RULE_19
    end
  endgenerate

  // Status byte as software sees it; unused bits read zero
  // Reading it has side effects: every flag set at that moment is armed
  always_comb begin
    status_view = '0;
    for (int i = 0; i < 2; i++) begin
      status_view[tccu_pkg::CAP_FLAG_BIT[i]] = st_q.cap_flag[i];
      status_view[tccu_pkg::CMP_FLAG_BIT[i]] = st_q.cmp_flag[i];
    end
    status_view[tccu_pkg::OVF_FLAG_BIT] = st_q.ovf_flag;
  end

  // Next-state logic for the whole unit
  // Clears come first and sets last below, so an event that falls in
  // the cycle of a clear is never lost
  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;

    // Two-stage synchroniser, then a third stage for the edge detector
    // No enable gates the pins, so driven outputs are captured as well
    st_d.sync1 = capture_pin; // RULE_26 RULE_09
    st_d.sync2 = st_q.sync1; // RULE_26
    st_d.sync3 = st_q.sync2;

    // Counter: software reload has priority over the advance pulse
    // cnt_new marks the one cycle in which compares look at a changed
    // count, so a count that dwells for many clocks matches only once
    st_d.cnt_new = tick;
    if (hit(reg_addr, tccu_pkg::CNT_LO_OFS, reg_wr) ||
        hit(reg_addr, tccu_pkg::ALT_LO_OFS, reg_wr)) begin
      st_d.cnt = tccu_pkg::CNT_RST; // RULE_25
      st_d.cnt_new = 1'b1;
    end else if (tick) begin
      st_d.cnt = st_q.cnt + 16'h0001; // RULE_23
    end

    // Overflow flag: clear step first so that a set in the same cycle wins
    // The alternate low byte reads the count without touching this flag
    if (st_q.ovf_arm && (hit(reg_addr, tccu_pkg::CNT_LO_OFS, reg_rd) ||
                         hit(reg_addr, tccu_pkg::CNT_LO_OFS, reg_wr))) begin
      st_d.ovf_flag = 1'b0;
      st_d.ovf_arm = 1'b0;
    end
    if (hit(reg_addr, tccu_pkg::STATUS_OFS, reg_rd) && st_q.ovf_flag) begin
      st_d.ovf_arm = 1'b1;
    end
    if (tick && (st_q.cnt == tccu_pkg::CNT_MAX) &&
        !hit(reg_addr, tccu_pkg::CNT_LO_OFS, reg_wr) &&
        !hit(reg_addr, tccu_pkg::ALT_LO_OFS, reg_wr)) begin
      st_d.ovf_flag = 1'b1; // RULE_23
    end

    // Capture channels
    for (int i = 0; i < 2; i++) begin
      // Flag clear takes two steps: status read while set, then low access
      // A low access without the armed status read leaves the flag set
      if (st_q.cap_arm[i] &&
          (hit(reg_addr, tccu_pkg::CAP_LO_OFS[i], reg_rd) ||
           hit(reg_addr, tccu_pkg::CAP_LO_OFS[i], reg_wr))) begin
        st_d.cap_flag[i] = 1'b0; // RULE_05
        st_d.cap_arm[i] = 1'b0;
      end
      if (hit(reg_addr, tccu_pkg::STATUS_OFS, reg_rd) &&
          st_q.cap_flag[i]) begin
        st_d.cap_arm[i] = 1'b1; // RULE_05
      end
      // High read freezes the channel so the low byte stays coherent
      if (hit(reg_addr, tccu_pkg::CAP_HI_OFS[i], reg_rd)) begin
        st_d.cap_inh[i] = 1'b1; // RULE_06
      end
      if (hit(reg_addr, tccu_pkg::CAP_LO_OFS[i], reg_rd)) begin
        st_d.cap_inh[i] = 1'b0; // RULE_06
      end
      // Latest event always overwrites; set beats any clear
      // The value is the count of the detect cycle, not of the pin event
      if (cap_event[i]) begin
        st_d.cap[i] = st_q.cnt; // RULE_01 RULE_07
        st_d.cap_flag[i] = 1'b1; // RULE_04 RULE_10 RULE_27
      end
      // Writes to capture values are deliberately not decoded: RULE_02
    end

    // Compare channels
    for (int i = 0; i < 2; i++) begin
      if (st_q.cmp_arm[i] &&
          (hit(reg_addr, tccu_pkg::CMP_LO_OFS[i], reg_rd) ||
           hit(reg_addr, tccu_pkg::CMP_LO_OFS[i], reg_wr))) begin
        st_d.cmp_flag[i] = 1'b0; // RULE_15
        st_d.cmp_arm[i] = 1'b0;
      end
      if (hit(reg_addr, tccu_pkg::STATUS_OFS, reg_rd) &&
          st_q.cmp_flag[i]) begin
        st_d.cmp_arm[i] = 1'b1; // RULE_15
      end
      // Byte writes; the high write suspends matching until the low write
      // Suspension covers the gap between the two halves of a new value
      if (hit(reg_addr, tccu_pkg::CMP_HI_OFS[i], reg_wr)) begin
        st_d.cmp[i][15:8] = reg_wdata; // RULE_13
        st_d.cmp_inh[i] = 1'b1; // RULE_16
      end
      if (hit(reg_addr, tccu_pkg::CMP_LO_OFS[i], reg_wr)) begin
        st_d.cmp[i][7:0] = reg_wdata; // RULE_13
        st_d.cmp_inh[i] = 1'b0; // RULE_16
      end
      if (cmp_match[i]) begin
        // Hardware flag is owned by the waveform modes on these channels
        if (!pwm_mode && !(pulse_mode && i == 0)) begin
          st_d.cmp_flag[i] = 1'b1; // RULE_12 RULE_18
        end
        // Level reaches the pin only when the pin belongs to the timer
        // The pin moves at the same edge as the flag would
        if (st_q.ctl_two[tccu_pkg::OE_BIT[i]]) begin
          st_d.pin[i] =
            st_q.ctl_one[tccu_pkg::LEVEL_BIT[i]]; // RULE_12 RULE_18
        end
      end
    end

    // Control writes; force bits act once and are not stored
    // Force needs the pin owned by the timer, or the level would be lost
    if (hit(reg_addr, tccu_pkg::CTL_ONE_OFS, reg_wr)) begin
      st_d.ctl_one = reg_wdata;
      st_d.ctl_one[tccu_pkg::FORCE_BIT[0]] = 1'b0;
      st_d.ctl_one[tccu_pkg::FORCE_BIT[1]] = 1'b0;
      for (int i = 0; i < 2; i++) begin
        // Force takes the level written in the same cycle, no flag
        if (reg_wdata[tccu_pkg::FORCE_BIT[i]] && !special_mode &&
            st_q.ctl_two[tccu_pkg::OE_BIT[i]]) begin // RULE_21
          st_d.pin[i] = reg_wdata[tccu_pkg::LEVEL_BIT[i]]; // RULE_20
        end
      end
    end
    if (hit(reg_addr, tccu_pkg::CTL_TWO_OFS, reg_wr)) begin
      st_d.ctl_two = reg_wdata;
    end

    // Counter high read buffers the low byte; MSB re-reads keep the buffer
    // This shields the low byte from a carry between the two reads
    if (hit(reg_addr, tccu_pkg::CNT_HI_OFS, reg_rd) ||
        hit(reg_addr, tccu_pkg::ALT_HI_OFS, reg_rd)) begin
      if (!st_q.cnt_buf_valid) begin
        st_d.cnt_buf = st_q.cnt[7:0];
        st_d.cnt_buf_valid = 1'b1;
      end
    end
    if (hit(reg_addr, tccu_pkg::CNT_LO_OFS, reg_rd) ||
        hit(reg_addr, tccu_pkg::ALT_LO_OFS, reg_rd)) begin
      st_d.cnt_buf_valid = 1'b0;
    end

    // Read data, presented the cycle after the strobe; unmapped reads zero
    // Zero outside the read cycle keeps a stale byte off the bus
    if (reg_rd) begin
      case (reg_addr)
        tccu_pkg::CTL_ONE_OFS: st_d.rdata = st_q.ctl_one;
        tccu_pkg::CTL_TWO_OFS: st_d.rdata = st_q.ctl_two;
        tccu_pkg::STATUS_OFS: st_d.rdata = status_view;
        tccu_pkg::CAP_HI_OFS[0]: st_d.rdata = st_q.cap[0][15:8];
        tccu_pkg::CAP_LO_OFS[0]: st_d.rdata = st_q.cap[0][7:0];
        tccu_pkg::CAP_HI_OFS[1]: st_d.rdata = st_q.cap[1][15:8];
        tccu_pkg::CAP_LO_OFS[1]: st_d.rdata = st_q.cap[1][7:0];
        tccu_pkg::CMP_HI_OFS[0]: st_d.rdata = st_q.cmp[0][15:8];
        tccu_pkg::CMP_LO_OFS[0]: st_d.rdata = st_q.cmp[0][7:0];
        tccu_pkg::CMP_HI_OFS[1]: st_d.rdata = st_q.cmp[1][15:8];
        tccu_pkg::CMP_LO_OFS[1]: st_d.rdata = st_q.cmp[1][7:0];
        tccu_pkg::CNT_HI_OFS, tccu_pkg::ALT_HI_OFS: begin
          st_d.rdata = st_q.cnt[15:8];
        end
        tccu_pkg::CNT_LO_OFS, tccu_pkg::ALT_LO_OFS: begin
          st_d.rdata = st_q.cnt_buf_valid ? st_q.cnt_buf : st_q.cnt[7:0];
        end
        default: st_d.rdata = '0;
      endcase
    end
  end

  // All core state but the tccu_tick prescaler and clock sync in one register; reset loads constants only
  // Counter and compare values have non-zero reset constants of their own
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0; // RULE_14
      st_q.cnt <= tccu_pkg::CNT_RST; // RULE_25
      st_q.cmp <= {tccu_pkg::CMP_RST, tccu_pkg::CMP_RST}; // RULE_13
    end else begin
      st_q <= st_d;
    end
  end

  // Shared interrupt: pending flags stay until enables and mask allow
  // The mask is applied last, so a masked request waits in the flags
  assign timer_irq = !cpu_irq_mask && (
    (st_q.ctl_one[tccu_pkg::CAP_IRQ_EN_BIT] && |st_q.cap_flag) || // RULE_04
    (st_q.ctl_one[tccu_pkg::CMP_IRQ_EN_BIT] && |st_q.cmp_flag) || // RULE_12
    (st_q.ctl_one[tccu_pkg::OVF_IRQ_EN_BIT] && st_q.ovf_flag));

  // Pin latches and their ownership come straight from flip-flops
  // With an enable low the pad is free for general I/O use
  assign compare_pin = st_q.pin;
  assign compare_output_enable = {st_q.ctl_two[tccu_pkg::OE_BIT[1]],
                                  st_q.ctl_two[tccu_pkg::OE_BIT[0]]};
  assign reg_rdata = st_q.rdata;

endmodule

`default_nettype wire

// ===== tccu_core_sva.sv
// Port-level property checker for the timer capture/compare unit
`default_nettype none

module tccu_core_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] capture_pin,
  input wire logic ext_clk_pin,
  input wire logic cpu_irq_mask,
  input wire logic [1:0] compare_pin,
  input wire logic [1:0] compare_output_enable,
  input wire logic timer_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic blk_q;

  // Shadow controls and the channel two block, seen only from the bus
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
      blk_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == tccu_pkg::CTL_ONE_OFS) c1_q <= reg_wdata;
      if (reg_wr && reg_addr == tccu_pkg::CTL_TWO_OFS) c2_q <= reg_wdata;
      if (reg_rd && reg_addr == tccu_pkg::CAP_HI_OFS[1]) blk_q <= 1'b1;
      if (reg_rd && reg_addr == tccu_pkg::CAP_LO_OFS[1]) blk_q <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_pin_reset_low: assert property (
    $fell(rst) |-> compare_pin == 2'b00)
    else $error("compare pins not low out of reset");
  a_irq_masked: assert property (
    cpu_irq_mask |-> !timer_irq)
    else $error("interrupt raised while masked");
  a_irq_cause: assert property (
    timer_irq |-> (c1_q[7] || c1_q[6] || c1_q[5]))
    else $error("interrupt raised with no source enabled");
  a_oe_follow: assert property (
    compare_output_enable == {c2_q[6], c2_q[7]})
    else $error("pin ownership differs from control two");
  a_ctl_two_read: assert property (
    reg_rd && reg_addr == tccu_pkg::CTL_TWO_OFS |=> reg_rdata == c2_q)
    else $error("control two read back wrong");
  a_ctl_one_read: assert property (
    reg_rd && reg_addr == tccu_pkg::CTL_ONE_OFS |=>
      reg_rdata == (c1_q & 8'he7))
    else $error("control one read back wrong");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr > tccu_pkg::ALT_LO_OFS |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_force_level: assert property (
    reg_wr && reg_addr == tccu_pkg::CTL_ONE_OFS && reg_wdata[3] &&
      compare_output_enable[0] && c2_q[5:4] == 2'b00 |->
      ##[1:2] compare_pin[0] == c1_q[0])
    else $error("forced level missing on pin one");
  a_cap_irq_time: assert property (
    $rose(capture_pin[1]) && c2_q[1] && c1_q[7] && !blk_q &&
      !cpu_irq_mask |-> ##[2:4] timer_irq)
    else $error("capture interrupt late");

  // Main scenarios reached
  cover property ($rose(timer_irq));
  cover property ($rose(compare_pin[1]));
  cover property (reg_rd && reg_addr == tccu_pkg::STATUS_OFS
    ##1 reg_rdata != 8'h00);
endmodule

bind tccu_core tccu_core_sva u_tccu_core_sva (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .capture_pin(capture_pin),
  .ext_clk_pin(ext_clk_pin), .cpu_irq_mask(cpu_irq_mask),
  .compare_pin(compare_pin), .compare_output_enable(compare_output_enable),
  .timer_irq(timer_irq)
);

`default_nettype wire

// ===== tccu_pin_model.sv
// Pin-side model: capture sources, external counter clock, compare pads
`default_nettype none

module tccu_pin_model (
  input wire logic ref_clk,
  input wire logic [1:0] compare_pin,
  input wire logic [1:0] compare_output_enable,
  output logic [1:0] capture_pin,
  output logic ext_clk_pin,
  output logic [1:0] pad_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pads are pulled up whenever the timer does not own them
  assign pad_level[0] = compare_output_enable[0] ? compare_pin[0] : 1'b1;
  assign pad_level[1] = compare_output_enable[1] ? compare_pin[1] : 1'b1;

  // Quiet pins at start; the external clock only moves inside a step
  initial begin
    capture_pin = 2'b00;
    ext_clk_pin = 1'b0;
  end

  // Full pulse; each level outlasts the two-stage synchroniser
  task automatic cap_pulse(input int ch);
    @(posedge ref_clk);
    capture_pin[ch] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    capture_pin[ch] <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // One counter advance; edges stay at least four clocks apart
  task automatic ext_step();
    @(posedge ref_clk);
    ext_clk_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ext_clk_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

// ===== tb.sv
// Self-checking bench for the timer capture/compare unit
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] C1 = tccu_pkg::CTL_ONE_OFS;
  localparam logic [7:0] C2 = tccu_pkg::CTL_TWO_OFS;
  localparam logic [7:0] ST = tccu_pkg::STATUS_OFS;
  localparam logic [7:0] CNL = tccu_pkg::CNT_LO_OFS;
  localparam logic [1:0][7:0] CPH = tccu_pkg::CAP_HI_OFS;
  localparam logic [1:0][7:0] CPL = tccu_pkg::CAP_LO_OFS;
  localparam logic [1:0][7:0] CMH = tccu_pkg::CMP_HI_OFS;
  localparam logic [1:0][7:0] CML = tccu_pkg::CMP_LO_OFS;
  logic ref_clk;
  logic rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [1:0] capture_pin;
  logic ext_clk_pin;
  logic cpu_irq_mask;
  logic [1:0] compare_pin;
  logic [1:0] compare_output_enable;
  logic timer_irq;
  logic [1:0] pad_level;
  int miscompares = 0;
  int comparisons = 0;

  tccu_core u_tccu_core (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .capture_pin(capture_pin),
    .ext_clk_pin(ext_clk_pin), .cpu_irq_mask(cpu_irq_mask),
    .compare_pin(compare_pin),
    .compare_output_enable(compare_output_enable), .timer_irq(timer_irq));
  tccu_pin_model u_pins (.ref_clk(ref_clk), .compare_pin(compare_pin),
    .compare_output_enable(compare_output_enable),
    .capture_pin(capture_pin), .ext_clk_pin(ext_clk_pin),
    .pad_level(pad_level));

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Data are sampled mid-cycle, well clear of the edge that updates them
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, exp);
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run length
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end

  // Counter is frozen on the external clock so every capture is exact
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cpu_irq_mask = 1'b1;
    repeat (6) @(posedge ref_clk);
    chk({6'h00, compare_pin}, 8'h00);
    rst <= 1'b0;
    wr(C2, 8'hcf);
    wr(C1, 8'hc6);
    rd(C2, 8'hcf);
    rd(C1, 8'hc6);
    rd(CMH[0], 8'h80);
    rd(CML[0], 8'h00);
    rd(8'h3f, 8'h00);
    wr(CNL, 8'h5a);
    rd(tccu_pkg::CNT_HI_OFS, 8'hff);
    rd(CNL, 8'hfc);
    wr(CMH[0], 8'h12);
    wr(CML[0], 8'h34);
    rd(CMH[0], 8'h12);
    rd(CML[0], 8'h34);
    u_pins.cap_pulse(0);
    chk({7'h00, timer_irq}, 8'h00);
    rd(ST, 8'h80);
    @(posedge ref_clk);
    cpu_irq_mask <= 1'b0;
    @(negedge ref_clk);
    chk({7'h00, timer_irq}, 8'h01);
    wr(CPH[0], 8'h55);
    rd(CPH[0], 8'hff);
    rd(CPL[0], 8'hfc);
    rd(ST, 8'h00);
    // A high-byte read holds channel two off until its low byte is read
    rd(CPH[1], 8'h00);
    u_pins.cap_pulse(1);
    rd(ST, 8'h00);
    rd(CPL[1], 8'h00);
    u_pins.cap_pulse(1);
    u_pins.ext_step();
    u_pins.cap_pulse(1);
    rd(ST, 8'h10);
    rd(CPH[1], 8'hff);
    rd(CPL[1], 8'hfd);
    // Compare on channel two, first with matching suspended
    wr(CMH[1], 8'hff);
    wr(CML[1], 8'hfe);
    wr(CMH[1], 8'hff);
    u_pins.ext_step();
    rd(ST, 8'h00);
    chk({6'h00, compare_pin}, 8'h00);
    wr(CML[1], 8'hfe);
    wr(CNL, 8'h00);
    u_pins.ext_step();
    u_pins.ext_step();
    rd(ST, 8'h08);
    chk({6'h00, compare_pin}, 8'h02);
    chk({7'h00, timer_irq}, 8'h01);
    u_pins.ext_step();
    u_pins.ext_step();
    rd(ST, 8'h28);
    wr(CML[1], 8'hfe);
    rd(ST, 8'h20);
    rd(CNL, 8'h00);
    rd(ST, 8'h00);
    // New value and level after the match give the next edge of a wave
    wr(C1, 8'hc2);
    wr(CMH[1], 8'h00);
    wr(CML[1], 8'h01);
    u_pins.ext_step();
    chk({6'h00, compare_pin}, 8'h00);
    rd(ST, 8'h08);
    wr(CML[1], 8'h01);
    // Force without flag, then force and channel one ignored in PWM
    wr(C1, 8'hcf);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({6'h00, compare_pin}, 8'h01);
    rd(ST, 8'h00);
    rd(C1, 8'hc7);
    wr(C2, 8'hdf);
    wr(C1, 8'hce);
    u_pins.cap_pulse(0);
    chk({6'h00, compare_pin}, 8'h01);
    rd(ST, 8'h00);
    wr(C2, 8'h8f);
    @(negedge ref_clk);
    chk({6'h00, compare_output_enable}, 8'h01);
    chk({6'h00, pad_level}, 8'h03);
    wrap_up();
  end
endmodule

`default_nettype wire
